// file: core/psfm_pkg.sv
// Package of constants and types for the power stage fault monitor
package psfm_pkg;

  // Temperature codes, one LSB per degree C
  localparam int TEMP_W = 8;
  localparam logic [7:0] OT_SET_TEMP = 8'h8C;
  localparam logic [7:0] OT_CLR_TEMP = 8'h7D;

  // Over-current counting
  localparam int OC_EVENTS_TO_FLAG = 10;
  localparam int OC_CLEAN_CYCLES = 3;
  localparam int CNT_W = 4;

  // Pin output select codes
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_TEMP = 2'h1;
  localparam logic [1:0] PIN_RAIL = 2'h2;

  // Pulse-width input decode
  typedef enum logic [1:0] {
    PSFM_PWM_LOW,
    PSFM_PWM_HIGH,
    PSFM_PWM_TRI
  } psfm_pwm_t;

endpackage

// file: core/psfm_cycle_counter.sv
// Cycle-by-cycle over-current event and clean-cycle counter
`timescale 1ns/1ps

module psfm_cycle_counter #(
  parameter int EVENTS = psfm_pkg::OC_EVENTS_TO_FLAG,
  parameter int CLEAN = psfm_pkg::OC_CLEAN_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_cycle_end,
  input wire logic i_cycle_oc,
  // Status
  output logic o_fault
);

  typedef struct packed {
    logic [psfm_pkg::CNT_W-1:0] events;
    logic [psfm_pkg::CNT_W-1:0] clean;
    logic fault;
  } psfm_cnt_state_t;

  psfm_cnt_state_t st;
  psfm_cnt_state_t next_st;

  function automatic logic [psfm_pkg::CNT_W-1:0] sat_inc(input logic [psfm_pkg::CNT_W-1:0] v,
                                                         input int lim);
    if (int'(v) >= lim) begin
      sat_inc = v;
    end else begin
      sat_inc = v + 4'h1;
    end
  endfunction

  always_comb begin
    next_st = st;
    if (i_clear) begin
      next_st = '0;
    end else if (i_cycle_end) begin
      if (i_cycle_oc) begin
        next_st.clean = '0;
        next_st.events = sat_inc(st.events, EVENTS);
        if (int'(next_st.events) >= EVENTS) begin
          next_st.fault = 1'b1;
        end
      end else begin
        next_st.clean = sat_inc(st.clean, CLEAN);
        if (int'(next_st.clean) >= CLEAN) begin
          next_st.events = '0;
          next_st.fault = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_fault = st.fault;

endmodule

// file: core/psfm_top.sv
// Fault supervision and gate override for a half-bridge power stage
`timescale 1ns/1ps
// Functional notes
// - Pin held low until power ready
// - Pin doubles as fault flag
// - Fault drives rail, else temperature
// - Over-temperature sets above set threshold
// - Over-temperature clears below release threshold
// - Over-temperature keeps gates following command
// - Over-current turns high gate off
// - High gate stays off until hysteresis
// - Ten events without three clean flag
// - Three clean cycles clear over-current
// - Over-current on high command turns both gates off
// - High-side short flags, keeps switching
// - Short clears on release, enable, power
// - Startup overvoltage holds low gate on
// - Reverse current turns low gate off
// - Resume low gate at release level
// - Hiccup between release and trip
// - Shared line carries highest output

module psfm_top #(
  parameter int TEMP_W = psfm_pkg::TEMP_W,
  parameter logic [7:0] OT_SET = psfm_pkg::OT_SET_TEMP,
  parameter logic [7:0] OT_CLR = psfm_pkg::OT_CLR_TEMP
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Controller side
  input wire logic i_enable,
  input wire logic i_pwm_high,
  input wire logic i_pwm_tri,
  // Supply and sensing
  input wire logic i_power_ready,
  input wire logic [TEMP_W-1:0] i_junction_temp,
  input wire logic i_overcurrent_trip,
  input wire logic i_overcurrent_release,
  input wire logic i_high_side_short,
  input wire logic i_startup_overvoltage_guard,
  input wire logic i_reverse_current_trip,
  input wire logic i_reverse_current_release,
  // Gate drives
  output logic o_high_gate_drive,
  output logic o_low_gate_drive,
  // Temperature and fault pin
  output logic [1:0] o_temp_fault_sel,
  output logic [TEMP_W-1:0] o_temp_fault_out,
  output logic o_fault_flag,
  output logic o_current_limit_hit
);

  typedef struct packed {
    logic hgate;
    logic lgate;
    logic [1:0] pin_sel;
    logic [TEMP_W-1:0] pin_val;
    logic flag;
    logic ot_fault;
    logic hs_block;
    logic ls_block;
    logic short_fault;
    logic startup;
    logic pwm_prev;
    logic cyc_oc;
    logic current_limit_hit;
  } psfm_state_t;

  psfm_state_t st;
  psfm_state_t next_st;
  logic active;
  logic cycle_end;
  logic oc_fault;
  logic any_fault;
  psfm_pkg::psfm_pwm_t pwm;

  // ****************************************
  // Pulse-width decode
  // ****************************************
  always_comb begin
    if (i_pwm_tri) begin
      pwm = psfm_pkg::PSFM_PWM_TRI;
    end else if (i_pwm_high) begin
      pwm = psfm_pkg::PSFM_PWM_HIGH;
    end else begin
      pwm = psfm_pkg::PSFM_PWM_LOW;
    end
  end

  // Active only when enabled and powered
  assign active = i_enable & i_power_ready;
  // One switching cycle ends on each rising command edge
  assign cycle_end = active & i_pwm_high & ~i_pwm_tri & ~st.pwm_prev;

  // ****************************************
  // Over-current cycle counting
  // ****************************************
  psfm_cycle_counter #(
    .EVENTS(psfm_pkg::OC_EVENTS_TO_FLAG),
    .CLEAN(psfm_pkg::OC_CLEAN_CYCLES)
  ) u_oc_count (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(~active),
    .i_cycle_end(cycle_end),
    .i_cycle_oc(st.cyc_oc),
    .o_fault(oc_fault)
  );

  assign any_fault = st.ot_fault | oc_fault | st.short_fault;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.pwm_prev = i_pwm_high & ~i_pwm_tri;
    if (!active) begin
      next_st = '0;
      next_st.startup = 1'b1;
      next_st.pin_sel = psfm_pkg::PIN_LOW;
    end else begin
      // Hysteresis keeps flag from chattering near the set point
      // over-temperature set
      if (i_junction_temp > OT_SET) begin
        next_st.ot_fault = 1'b1;
      end else if (i_junction_temp < OT_CLR) begin
        next_st.ot_fault = 1'b0;
      end
      next_st.short_fault = i_high_side_short;
      if (i_overcurrent_trip) begin
        next_st.hs_block = 1'b1;
      end else if (i_overcurrent_release) begin
        next_st.hs_block = 1'b0;
      end
      // Trip on the opening edge belongs to the new cycle, never counted twice
      if (cycle_end) begin
        next_st.cyc_oc = i_overcurrent_trip;
      end else if (i_overcurrent_trip) begin
        next_st.cyc_oc = 1'b1;
      end
      if (i_reverse_current_trip) begin
        next_st.ls_block = 1'b1;
      end else if (i_reverse_current_release) begin
        next_st.ls_block = 1'b0;
      end
      // Startup window ends at first non-tri-state command while the overvoltage guard is low
      if (pwm != psfm_pkg::PSFM_PWM_TRI && !i_startup_overvoltage_guard) begin
        next_st.startup = 1'b0;
      end
      unique case (pwm)
        psfm_pkg::PSFM_PWM_HIGH: begin
          next_st.hgate = ~(i_overcurrent_trip | next_st.hs_block);
          next_st.lgate = 1'b0;
        end
        psfm_pkg::PSFM_PWM_LOW: begin
          next_st.hgate = 1'b0;
          next_st.lgate = ~(i_reverse_current_trip | next_st.ls_block);
        end
        psfm_pkg::PSFM_PWM_TRI: begin
          next_st.hgate = 1'b0;
          next_st.lgate = 1'b0;
        end
      endcase
      if (st.startup && i_startup_overvoltage_guard) begin
        next_st.hgate = 1'b0;
        next_st.lgate = 1'b1;
      end
      next_st.current_limit_hit = (pwm == psfm_pkg::PSFM_PWM_HIGH) & (i_overcurrent_trip | next_st.hs_block);
      next_st.flag = any_fault;
      if (any_fault) begin
        next_st.pin_sel = psfm_pkg::PIN_RAIL;
        next_st.pin_val = '1;
      end else begin
        next_st.pin_sel = psfm_pkg::PIN_TEMP;
        next_st.pin_val = i_junction_temp;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.startup <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_high_gate_drive = st.hgate;
  assign o_low_gate_drive = st.lgate;
  assign o_temp_fault_sel = st.pin_sel;
  assign o_temp_fault_out = st.pin_val;
  assign o_fault_flag = st.flag;
  assign o_current_limit_hit = st.current_limit_hit;

endmodule

// file: tb/psfm_checker.sv
// Port checks on the power stage fault monitor
`timescale 1ns/1ps
module psfm_checker #(
  parameter int TEMP_W = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Inputs
  input wire logic i_enable,
  input wire logic i_pwm_high,
  input wire logic i_pwm_tri,
  input wire logic i_power_ready,
  input wire logic [TEMP_W-1:0] i_junction_temp,
  input wire logic i_overcurrent_trip,
  input wire logic i_overcurrent_release,
  input wire logic i_high_side_short,
  input wire logic i_startup_overvoltage_guard,
  input wire logic i_reverse_current_trip,
  // Outputs
  input wire logic o_high_gate_drive,
  input wire logic o_low_gate_drive,
  input wire logic [1:0] o_temp_fault_sel,
  input wire logic [TEMP_W-1:0] o_temp_fault_out,
  input wire logic o_fault_flag
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic act = i_enable && i_power_ready;
  a_pin_low_unready: assert property (!i_power_ready |=> o_temp_fault_sel == 2'h0)
    else $error("pin not low");
  a_fault_on_rail: assert property (o_fault_flag |-> o_temp_fault_sel == 2'h2 && o_temp_fault_out == 8'hFF)
    else $error("fault not on rail");
  a_temp_passed: assert property (o_temp_fault_sel == 2'h1 |-> o_temp_fault_out == $past(i_junction_temp))
    else $error("temperature wrong");
  a_hot_flags: assert property ((act && i_junction_temp > 8'h8C) [*2] |=> o_fault_flag)
    else $error("hot without flag");
  a_short_flags: assert property ((act && i_high_side_short) [*2] |=> o_fault_flag)
    else $error("short without flag");
  a_trip_gate_off: assert property (i_overcurrent_trip |=> !o_high_gate_drive)
    else $error("high gate on at trip");
  a_trip_hold: assert property (i_overcurrent_trip ##1 !i_overcurrent_release |=> !o_high_gate_drive)
    else $error("high gate back early");
  a_gate_follows: assert property (act && i_pwm_high && !i_pwm_tri && i_overcurrent_release
    && !i_overcurrent_trip && !i_startup_overvoltage_guard |=> o_high_gate_drive)
    else $error("high gate ignores command");
  a_reverse_off: assert property (i_reverse_current_trip && !i_startup_overvoltage_guard |=> !o_low_gate_drive)
    else $error("low gate on at reverse trip");
  a_idle_clear: assert property (!i_enable |=> !o_high_gate_drive && !o_low_gate_drive && !o_fault_flag)
    else $error("idle outputs not clear");
endmodule
bind psfm_top psfm_checker #(.TEMP_W(TEMP_W)) u_psfm_checker (.*);

// file: tb/psfm_ctrl_model.sv
// Controller model: pulse-width command and merged pin line
`timescale 1ns/1ps
module psfm_ctrl_model (
  // Clock and command
  input wire logic i_core_clk,
  input wire logic [1:0] i_cmd,
  // Pin values of two stages
  input wire logic [7:0] i_pin_a,
  input wire logic [7:0] i_pin_b,
  // Drives and merged line
  output logic o_pwm_high,
  output logic o_pwm_tri,
  output logic [7:0] o_shared
);
  // ****************
  // Behaviour
  // ****************
  logic flip = 1'b0;
  // No defined level in the window, so keep it moving
  always @(negedge i_core_clk) flip <= !flip;
  assign o_pwm_tri = i_cmd == 2'h2;
  assign o_pwm_high = o_pwm_tri ? flip : i_cmd == 2'h1;
  assign o_shared = i_pin_a > i_pin_b ? i_pin_a : i_pin_b;
endmodule

// file: tb/tb_psfm_top.sv
// Self-checking bench for the power stage fault monitor
`timescale 1ns/1ps
module tb_psfm_top;
  // ****************
  // Stimulus and checks
  // ****************
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_enable = 1'b0, i_power_ready = 1'b0;
  logic i_overcurrent_trip = 1'b0, i_overcurrent_release = 1'b1, i_high_side_short = 1'b0;
  logic i_startup_overvoltage_guard = 1'b0, i_reverse_current_trip = 1'b0, i_reverse_current_release = 1'b1;
  logic i_pwm_high, i_pwm_tri, o_high_gate_drive, o_low_gate_drive, o_fault_flag, o_current_limit_hit;
  logic [1:0] cmd = 2'h0;
  logic [1:0] o_temp_fault_sel;
  logic [7:0] i_junction_temp = 8'h19;
  logic [7:0] o_temp_fault_out, shared;
  int err_total = 0;
  int n_checks = 0;
  psfm_top u_psfm_top (.*);
  psfm_ctrl_model u_psfm_ctrl_model (.i_core_clk, .i_cmd(cmd), .i_pin_a(o_temp_fault_out), .i_pin_b(8'h30),
    .o_pwm_high(i_pwm_high), .o_pwm_tri(i_pwm_tri), .o_shared(shared));
  initial forever #5 i_core_clk = ~i_core_clk;
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One switching cycle, trip held through the high phase
  task automatic cyc(input logic oc);
    cmd = 2'h1;
    i_overcurrent_trip = oc;
    i_overcurrent_release = !oc;
    step(3);
    if (oc) chk("limit", 1'h1, o_current_limit_hit);
    cmd = 2'h0;
    i_overcurrent_trip = 1'b0;
    i_overcurrent_release = 1'b1;
    step(3);
    chk("low gate", 1'h1, o_low_gate_drive);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Run needs about 215 cycles
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    step(5);
    i_rst = 1'b0;
    i_enable = 1'b1;
    step(3);
    chk("sel", 2'h0, o_temp_fault_sel);
    i_power_ready = 1'b1;
    step(3);
    chk("pin", 8'h19, o_temp_fault_out);
    chk("shared", 8'h30, shared);
    i_junction_temp = 8'h8C;
    step(3);
    chk("flag", 1'h0, o_fault_flag);
    i_junction_temp = 8'h8D;
    step(3);
    chk("flag", 1'h1, o_fault_flag);
    chk("shared", 8'hFF, shared);
    cmd = 2'h1;
    step(2);
    chk("high gate", 1'h1, o_high_gate_drive);
    i_junction_temp = 8'h7D;
    step(3);
    chk("flag", 1'h1, o_fault_flag);
    i_junction_temp = 8'h7C;
    cmd = 2'h0;
    step(3);
    chk("flag", 1'h0, o_fault_flag);
    repeat (10) cyc(1'b1);
    chk("flag", 1'h0, o_fault_flag);
    repeat (3) cyc(1'b0);
    chk("flag", 1'h1, o_fault_flag);
    chk("sel", 2'h2, o_temp_fault_sel);
    cyc(1'b0);
    chk("flag", 1'h0, o_fault_flag);
    repeat (9) cyc(1'b1);
    repeat (3) cyc(1'b0);
    cyc(1'b1);
    cyc(1'b0);
    chk("flag", 1'h0, o_fault_flag);
    i_high_side_short = 1'b1;
    cmd = 2'h1;
    step(3);
    chk("flag", 1'h1, o_fault_flag);
    chk("high gate", 1'h1, o_high_gate_drive);
    i_high_side_short = 1'b0;
    cmd = 2'h0;
    step(3);
    chk("flag", 1'h0, o_fault_flag);
    i_reverse_current_trip = 1'b1;
    i_reverse_current_release = 1'b0;
    step(2);
    chk("low gate", 1'h0, o_low_gate_drive);
    i_reverse_current_trip = 1'b0;
    step(2);
    chk("low gate", 1'h0, o_low_gate_drive);
    i_reverse_current_release = 1'b1;
    step(2);
    chk("low gate", 1'h1, o_low_gate_drive);
    i_enable = 1'b0;
    step(2);
    chk("low gate", 1'h0, o_low_gate_drive);
    i_startup_overvoltage_guard = 1'b1;
    cmd = 2'h2;
    i_enable = 1'b1;
    step(3);
    chk("low gate", 1'h1, o_low_gate_drive);
    cmd = 2'h1;
    step(2);
    chk("high gate", 1'h0, o_high_gate_drive);
    i_startup_overvoltage_guard = 1'b0;
    step(2);
    chk("high gate", 1'h1, o_high_gate_drive);
    complete_run();
  end
endmodule
